// *** radio_cfg.svh ***
/*
  Constants of the radio state controller: strobe codes, state numbers,
  setting encodings and transition times in crystal periods.
  Assumes the core clock is the crystal clock itself.
*/
`ifndef RADIO_CFG_SVH
`define RADIO_CFG_SVH

`define CODE_W 4
`define STROBE_RESET 4'h0
`define STROBE_OSC_OFF 4'h1
`define STROBE_POWER_DOWN 4'h2
`define STROBE_RECEIVE 4'h3
`define STROBE_TRANSMIT 4'h4
`define STROBE_SYNTH_ON 4'h5
`define STROBE_CALIBRATE 4'h6
`define STROBE_IDLE 4'h7

`define NUM_W 5
`define NUM_SLEEP 5'h00
`define NUM_IDLE 5'h01
`define NUM_OSC_OFF 5'h02
`define NUM_STARTUP 5'h03
`define NUM_CAL 5'h04
`define NUM_SETTLE 5'h05
`define NUM_RX 5'h06
`define NUM_TX 5'h07
`define NUM_SYNTH 5'h08
`define NUM_TURN 5'h09

`define ACAL_NEVER 2'h0
`define ACAL_FROM_IDLE 2'h1
`define ACAL_TO_IDLE 2'h2
`define ACAL_FOURTH 2'h3
`define ACAL_LAST 2'h3

`define AFTER_IDLE 2'h0
`define AFTER_SYNTH 2'h1
`define AFTER_TX 2'h2
`define AFTER_RX 2'h3

`define CCA_ALWAYS 2'h0
`define CCA_RSSI 2'h1
`define CCA_NOT_RX 2'h2
`define CCA_BOTH 2'h3

`define TIMER_W 15
`define XOSC_PER_CLK 1
`define CAL_PERIODS 18739
`define SETTLE_PERIODS 2298
`define TX_TO_RX_PERIODS 560
`define RX_TO_TX_PERIODS 250
`define TO_IDLE_PERIODS 2
`define CAL_CYCLES (`CAL_PERIODS * `XOSC_PER_CLK)
`define SETTLE_CYCLES (`SETTLE_PERIODS * `XOSC_PER_CLK)
`define TX_TO_RX_CYCLES (`TX_TO_RX_PERIODS * `XOSC_PER_CLK)
`define RX_TO_TX_CYCLES (`RX_TO_TX_PERIODS * `XOSC_PER_CLK)
`define TO_IDLE_CYCLES (`TO_IDLE_PERIODS * `XOSC_PER_CLK)

`endif

// *** radio_pkg.sv ***
/*
  Types of the radio state controller.
  Assumes radio_cfg.svh supplies the widths.
*/
`include "radio_cfg.svh"
package radio_pkg;
  typedef logic [`CODE_W-1:0] strobe_code_t;
  typedef logic [`NUM_W-1:0] state_number_t;
  typedef logic [`TIMER_W-1:0] count_t;
  typedef logic [1:0] select_t;
  typedef enum logic [9:0] {
    ST_SLEEP = 10'b0000000001,
    ST_IDLE = 10'b0000000010,
    ST_OSC_OFF = 10'b0000000100,
    ST_STARTUP = 10'b0000001000,
    ST_CAL = 10'b0000010000,
    ST_SETTLE = 10'b0000100000,
    ST_RX = 10'b0001000000,
    ST_TX = 10'b0010000000,
    ST_SYNTH = 10'b0100000000,
    ST_TURN = 10'b1000000000
  } state_t;
endpackage

// *** strobe_crossing.sv ***
/*
  Carries a command strobe from the serial link clock into the core clock
  by a toggle handshake. Assumes strobes are several core cycles apart,
  so the held code is stable when the toggle edge is seen.
*/
`timescale 1ns/1ps
module strobe_crossing (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic link_clk_in,
  input wire logic strobe_valid_in,
  input wire radio_pkg::strobe_code_t strobe_code_in,
  output logic strobe_pulse_out,
  output radio_pkg::strobe_code_t strobe_code_out
);
  import radio_pkg::*;
  logic lrst_meta_reg, lrst_reg;
  logic tog_reg, tog_next;
  strobe_code_t held_reg, held_next;
  logic tmeta_reg, tsync_reg, tlast_reg;
  logic pulse_next;
  strobe_code_t code_next;

  // Reset reaches the link domain through two flops of its own.
  always_ff @(posedge link_clk_in)
  begin
    lrst_meta_reg <= resetn_in;
    lrst_reg <= lrst_meta_reg;
  end

  // Each link strobe flips the toggle and holds its code.
  always_comb
  begin
    tog_next = tog_reg;
    held_next = held_reg;
    if (!lrst_reg)
    begin
      tog_next = 1'b0;
      held_next = '0;
    end
    else if (strobe_valid_in)
    begin
      tog_next = !tog_reg;
      held_next = strobe_code_in;
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    tog_reg <= tog_next;
    held_reg <= held_next;
  end

  // A change of the synchronised toggle marks one strobe.
  always_comb
  begin
    pulse_next = resetn_in && (tsync_reg != tlast_reg);
    code_next = pulse_next ? held_reg : strobe_code_out;
  end

  always_ff @(posedge clk_in)
  begin
    tmeta_reg <= tog_reg;
    tsync_reg <= tmeta_reg;
    if (!resetn_in)
    begin
      tlast_reg <= 1'b0;
      strobe_pulse_out <= 1'b0;
      strobe_code_out <= '0;
    end
    else
    begin
      tlast_reg <= tsync_reg;
      strobe_pulse_out <= pulse_next;
      strobe_code_out <= code_next;
    end
  end
endmodule

// *** wait_timer.sv ***
/*
  Down counter for fixed transition times. A load with count N gives a
  one-cycle done pulse N cycles later. Assumes N is at least 1.
*/
`timescale 1ns/1ps
module wait_timer (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic load_in,
  input wire radio_pkg::count_t count_in,
  output logic done_out
);
  import radio_pkg::*;
  count_t cnt_reg, cnt_next;
  logic done_next;

  // A new load restarts the wait, so an aborted transition leaves no trace.
  always_comb
  begin
    done_next = 1'b0;
    cnt_next = cnt_reg;
    if (load_in)
      cnt_next = count_in;
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - 1'b1;
      done_next = (cnt_reg == count_t'(1));
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      cnt_reg <= '0;
      done_out <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      done_out <= done_next;
    end
  end
endmodule

// *** radio_state_controller.sv ***
/*
  Main operating-state controller of the transceiver: start-up, sleep and
  oscillator-off, synthesizer calibration, receive, transmit and their
  turnarounds. Assumes strobes arrive decoded on the serial link clock and
  that packet events and settings come from logic on the core clock.
*/
`timescale 1ns/1ps
`include "radio_cfg.svh"
module radio_state_controller #(
  parameter int CAL_LEN = `CAL_CYCLES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic link_clk_in,
  input wire logic strobe_valid_in,
  input wire radio_pkg::strobe_code_t strobe_code_in,
  input wire logic chip_select_low_in,
  input wire logic osc_stable_in,
  input wire logic xosc_force_on_in,
  input wire radio_pkg::select_t auto_calibration_select_in,
  input wire radio_pkg::select_t after_receive_state_in,
  input wire radio_pkg::select_t after_transmit_state_in,
  input wire radio_pkg::select_t clear_channel_mode_in,
  input wire logic rssi_below_in,
  input wire logic receiving_packet_in,
  input wire logic packet_received_in,
  input wire logic packet_sent_in,
  input wire logic rx_timeout_in,
  input wire logic tx_underflow_in,
  input wire logic wor_wake_in,
  output logic ready_low_flag_out,
  output radio_pkg::state_number_t radio_state_number_out,
  output logic xosc_enable_out,
  output logic regulator_enable_out,
  output logic synth_cal_out,
  output logic synth_enable_out,
  output logic rx_enable_out,
  output logic tx_enable_out
);
  import radio_pkg::*;
  logic cs_meta_reg, cs_sync_reg, cs_prev_reg;
  logic osc_meta_reg, osc_sync_reg;
  logic stb;
  strobe_code_t code;
  logic tdone;
  logic tload;
  count_t tcount;
  state_t state_reg, state_next;
  state_t target_reg, target_next;
  logic pend_off_reg, pend_off_next;
  logic pend_sleep_reg, pend_sleep_next;
  logic [1:0] acal_cnt_reg, acal_cnt_next;
  logic cca_ok, cs_release, auto_idle;
  logic s_reset, s_off, s_pdown, s_rx, s_tx, s_fs, s_cal, s_idle;
  state_number_t num_next;

  strobe_crossing crossing (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .link_clk_in(link_clk_in),
    .strobe_valid_in(strobe_valid_in),
    .strobe_code_in(strobe_code_in),
    .strobe_pulse_out(stb),
    .strobe_code_out(code)
  );

  wait_timer timer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .load_in(tload),
    .count_in(tcount),
    .done_out(tdone)
  );

  // Pins from outside the core clock pass two flops before use.
  always_ff @(posedge clk_in)
  begin
    cs_meta_reg <= chip_select_low_in;
    cs_sync_reg <= cs_meta_reg;
    cs_prev_reg <= cs_sync_reg;
    osc_meta_reg <= osc_stable_in;
    osc_sync_reg <= osc_meta_reg;
  end

  // Strobe decode and the clear-channel test.
  always_comb
  begin
    s_reset = stb && (code == `STROBE_RESET);
    s_off = stb && (code == `STROBE_OSC_OFF);
    s_pdown = stb && (code == `STROBE_POWER_DOWN);
    s_rx = stb && (code == `STROBE_RECEIVE);
    s_tx = stb && (code == `STROBE_TRANSMIT);
    s_fs = stb && (code == `STROBE_SYNTH_ON);
    s_cal = stb && (code == `STROBE_CALIBRATE);
    s_idle = stb && (code == `STROBE_IDLE);
    cs_release = cs_prev_reg && !cs_sync_reg;
    unique case (clear_channel_mode_in)
      `CCA_ALWAYS: cca_ok = 1'b1;
      `CCA_RSSI: cca_ok = rssi_below_in;
      `CCA_NOT_RX: cca_ok = !receiving_packet_in;
      `CCA_BOTH: cca_ok = rssi_below_in && !receiving_packet_in;
    endcase
  end

  // Next state. Priority: reset strobe, idle strobe, then per state.
  // Strobes not listed for a state fall through and change nothing.
  always_comb
  begin
    state_next = state_reg;
    target_next = target_reg;
    pend_off_next = pend_off_reg;
    pend_sleep_next = pend_sleep_reg;
    acal_cnt_next = acal_cnt_reg;
    tload = 1'b0;
    tcount = count_t'(`TO_IDLE_CYCLES);
    auto_idle = 1'b0;
    if (s_reset)
    begin
      state_next = ST_STARTUP;
      target_next = ST_IDLE;
      pend_off_next = 1'b0;
      pend_sleep_next = 1'b0;
      acal_cnt_next = 2'h0;
    end
    else if (s_idle)
    begin
      pend_off_next = 1'b0;
      pend_sleep_next = 1'b0;
      // No calibration here; a sleeping core must restart first.
      if (state_reg inside {ST_SLEEP, ST_OSC_OFF, ST_STARTUP})
        state_next = ST_STARTUP;
      else
        state_next = ST_IDLE;
    end
    else
    begin
      unique case (state_reg)
        ST_STARTUP:
          if (osc_sync_reg)
            state_next = ST_IDLE;
        ST_SLEEP, ST_OSC_OFF:
          if (cs_sync_reg)
            state_next = ST_STARTUP;
        ST_IDLE:
        begin
          if (pend_off_reg || pend_sleep_reg)
          begin
            if (cs_release)
            begin
              state_next = pend_sleep_reg ? ST_SLEEP : ST_OSC_OFF;
              pend_off_next = 1'b0;
              pend_sleep_next = 1'b0;
            end
          end
          else if (s_off)
            pend_off_next = 1'b1;
          else if (s_pdown)
            pend_sleep_next = 1'b1;
          else if (s_cal)
          begin
            state_next = ST_CAL;
            target_next = ST_IDLE;
            tload = 1'b1;
            tcount = count_t'(CAL_LEN);
          end
          else if (s_rx || s_tx || s_fs || wor_wake_in)
          begin
            target_next = s_tx ? ST_TX : (s_fs ? ST_SYNTH : ST_RX);
            tload = 1'b1;
            if (auto_calibration_select_in == `ACAL_FROM_IDLE)
            begin
              state_next = ST_CAL;
              tcount = count_t'(CAL_LEN);
            end
            else
            begin
              state_next = ST_SETTLE;
              tcount = count_t'(`SETTLE_CYCLES);
            end
          end
        end
        ST_CAL:
          if (tdone)
          begin
            if (target_reg == ST_IDLE)
              state_next = ST_IDLE;
            else
            begin
              state_next = ST_SETTLE;
              tload = 1'b1;
              tcount = count_t'(`SETTLE_CYCLES);
            end
          end
        ST_SETTLE, ST_TURN:
          if (tdone)
            state_next = target_reg;
        ST_RX:
        begin
          if ((s_tx || s_fs) && cca_ok)
          begin
            state_next = ST_TURN;
            target_next = s_tx ? ST_TX : ST_SYNTH;
            tload = 1'b1;
            tcount = count_t'(`RX_TO_TX_CYCLES);
          end
          else if (packet_received_in)
          begin
            unique case (after_receive_state_in)
              `AFTER_IDLE: auto_idle = 1'b1;
              `AFTER_SYNTH, `AFTER_TX:
              begin
                state_next = ST_TURN;
                target_next = (after_receive_state_in == `AFTER_TX) ?
                  ST_TX : ST_SYNTH;
                tload = 1'b1;
                tcount = count_t'(`RX_TO_TX_CYCLES);
              end
              `AFTER_RX: state_next = ST_RX;
            endcase
          end
          else if (rx_timeout_in)
            auto_idle = 1'b1;
        end
        ST_TX:
        begin
          if (s_rx)
          begin
            state_next = ST_TURN;
            target_next = ST_RX;
            tload = 1'b1;
            tcount = count_t'(`TX_TO_RX_CYCLES);
          end
          else if (tx_underflow_in)
            state_next = ST_IDLE;
          else if (packet_sent_in)
          begin
            unique case (after_transmit_state_in)
              `AFTER_IDLE: auto_idle = 1'b1;
              `AFTER_SYNTH: state_next = ST_SYNTH;
              `AFTER_TX: state_next = ST_TX;
              `AFTER_RX:
              begin
                state_next = ST_TURN;
                target_next = ST_RX;
                tload = 1'b1;
                tcount = count_t'(`TX_TO_RX_CYCLES);
              end
            endcase
          end
        end
        ST_SYNTH:
          if (s_tx)
            state_next = ST_TX;
          else if (s_rx)
          begin
            state_next = ST_TURN;
            target_next = ST_RX;
            tload = 1'b1;
            tcount = count_t'(`TX_TO_RX_CYCLES);
          end
        default:
          state_next = ST_STARTUP;
      endcase
      // Automatic return to idle applies the calibration policy.
      if (auto_idle)
      begin
        target_next = ST_IDLE;
        tload = 1'b1;
        state_next = ST_TURN;
        tcount = count_t'(`TO_IDLE_CYCLES);
        if ((auto_calibration_select_in == `ACAL_TO_IDLE) ||
            ((auto_calibration_select_in == `ACAL_FOURTH) &&
             (acal_cnt_reg == `ACAL_LAST)))
        begin
          state_next = ST_CAL;
          tcount = count_t'(CAL_LEN);
        end
        if (auto_calibration_select_in == `ACAL_FOURTH)
          acal_cnt_next = acal_cnt_reg + 2'h1;
      end
    end
  end

  // State number shown as status, mapped from the one-hot state.
  always_comb
  begin
    unique case (state_next)
      ST_SLEEP: num_next = `NUM_SLEEP;
      ST_IDLE: num_next = `NUM_IDLE;
      ST_OSC_OFF: num_next = `NUM_OSC_OFF;
      ST_STARTUP: num_next = `NUM_STARTUP;
      ST_CAL: num_next = `NUM_CAL;
      ST_SETTLE: num_next = `NUM_SETTLE;
      ST_RX: num_next = `NUM_RX;
      ST_TX: num_next = `NUM_TX;
      ST_SYNTH: num_next = `NUM_SYNTH;
      ST_TURN: num_next = `NUM_TURN;
      default: num_next = `NUM_STARTUP;
    endcase
  end

  // Outputs are registered from the next state so they change together
  // with the state itself.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state_reg <= ST_STARTUP;
      target_reg <= ST_IDLE;
      pend_off_reg <= 1'b0;
      pend_sleep_reg <= 1'b0;
      acal_cnt_reg <= 2'h0;
      ready_low_flag_out <= 1'b1;
      radio_state_number_out <= `NUM_STARTUP;
      xosc_enable_out <= 1'b1;
      regulator_enable_out <= 1'b1;
      synth_cal_out <= 1'b0;
      synth_enable_out <= 1'b0;
      rx_enable_out <= 1'b0;
      tx_enable_out <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      target_reg <= target_next;
      pend_off_reg <= pend_off_next;
      pend_sleep_reg <= pend_sleep_next;
      acal_cnt_reg <= acal_cnt_next;
      // Ready only with a stable oscillator outside start-up, sleep and oscillator-off.
      ready_low_flag_out <= !(osc_sync_reg && (state_next != ST_STARTUP) &&
        (state_next != ST_SLEEP) && (state_next != ST_OSC_OFF));
      radio_state_number_out <= num_next;
      xosc_enable_out <= xosc_force_on_in ||
        !(state_next inside {ST_SLEEP, ST_OSC_OFF});
      regulator_enable_out <= (state_next != ST_SLEEP);
      synth_cal_out <= (state_next == ST_CAL);
      synth_enable_out <= state_next inside {ST_SETTLE, ST_RX, ST_TX,
        ST_SYNTH, ST_TURN};
      rx_enable_out <= (state_next == ST_RX);
      tx_enable_out <= (state_next == ST_TX);
    end
  end
endmodule

// *** radio_state_controller_chk.sv ***
/*
  Checker for the radio state controller, bound to its top-level ports.
  Assumes one core clock domain and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module radio_state_controller_chk #(
  parameter int CAL_LEN = 20
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic xosc_force_on_in,
  input wire radio_pkg::select_t auto_calibration_select_in,
  input wire logic ready_low_flag_out,
  input wire radio_pkg::state_number_t radio_state_number_out,
  input wire logic xosc_enable_out,
  input wire logic regulator_enable_out,
  input wire logic synth_cal_out,
  input wire logic synth_enable_out,
  input wire logic rx_enable_out,
  input wire logic tx_enable_out
);
  import radio_pkg::*;
  state_number_t prev_reg, prev_next, st;
  logic [15:0] dwell_reg, dwell_next;
  logic moved;
  // Dwell holds how long the previous state lasted, so that every timed
  // transition is judged at the cycle where the state number changes.
  assign st = radio_state_number_out;
  assign moved = (st != prev_reg);
  always_comb
  begin
    prev_next = st;
    dwell_next = moved ? 16'h0001 : dwell_reg + 16'h0001;
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      prev_reg <= 5'h03;
      dwell_reg <= 16'h0000;
    end
    else
    begin
      prev_reg <= prev_next;
      dwell_reg <= dwell_next;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  a_ready_level: assert property (
    ready_low_flag_out == (st inside {5'h00, 5'h02, 5'h03}))
    else $error("Ready flag disagrees with the state.");
  a_sleep_reg: assert property (
    st == 5'h00 |-> !regulator_enable_out)
    else $error("Regulator on while asleep.");
  a_sleep_xosc: assert property (
    (!xosc_force_on_in)[*3] ##0 (st inside {5'h00, 5'h02})
    |-> !xosc_enable_out)
    else $error("Oscillator on while stopped.");
  a_force_xosc: assert property (
    xosc_force_on_in[*3] |-> xosc_enable_out)
    else $error("Oscillator off although forced on.");
  a_rx_enable: assert property (
    st == 5'h06 |-> rx_enable_out && !tx_enable_out)
    else $error("Receive state without receiver.");
  a_tx_enable: assert property (
    st == 5'h07 |-> tx_enable_out && !rx_enable_out)
    else $error("Transmit state without transmitter.");
  a_cal_len: assert property (
    moved && prev_reg == 5'h04 |-> dwell_reg inside {[CAL_LEN:CAL_LEN+2]})
    else $error("Calibration length wrong.");
  a_settle_len: assert property (
    moved && prev_reg == 5'h05 |-> dwell_reg inside {[2298:2300]})
    else $error("Settle length wrong.");
  a_turn_to_tx: assert property (
    moved && prev_reg == 5'h09 && st inside {5'h07, 5'h08}
    |-> dwell_reg inside {[250:252]})
    else $error("Receive to transmit turnaround wrong.");
  a_turn_to_rx: assert property (
    moved && prev_reg == 5'h09 && st == 5'h06
    |-> dwell_reg inside {[560:562]})
    else $error("Transmit to receive turnaround wrong.");
  // The short turnaround back to idle has its own fixed length.
  a_turn_idle: assert property (
    moved && prev_reg == 5'h09 && st == 5'h01
    |-> dwell_reg inside {[2:4]})
    else $error("Turnaround to idle wrong.");
  a_cal_synth: assert property (
    synth_cal_out == (st == 5'h04))
    else $error("Calibration output disagrees with the state.");
  a_synth_on: assert property (
    synth_enable_out == (st inside {5'h05, 5'h06, 5'h07, 5'h08, 5'h09}))
    else $error("Synthesizer enable disagrees with the state.");
  a_idle_nocal: assert property (
    moved && st == 5'h04 && prev_reg inside {5'h06, 5'h07}
    |-> auto_calibration_select_in inside {2'h2, 2'h3})
    else $error("Calibration after active state not selected.");
  a_wake_path: assert property (
    moved && prev_reg == 5'h00 |-> st == 5'h03)
    else $error("Sleep left other than via start-up.");
  a_startup_exit: assert property (
    moved && prev_reg == 5'h03 |-> st == 5'h01)
    else $error("Start-up left other than to idle.");
  c_turn_tx: cover property (moved && prev_reg == 5'h09 && st == 5'h07);
  c_wake: cover property (moved && prev_reg == 5'h00);
  c_cal_idle: cover property (moved && prev_reg == 5'h04 && st == 5'h01);
endmodule

bind radio_state_controller radio_state_controller_chk #(
  .CAL_LEN(CAL_LEN)
) chk (.clk_in, .resetn_in, .xosc_force_on_in, .auto_calibration_select_in,
  .ready_low_flag_out, .radio_state_number_out, .xosc_enable_out,
  .regulator_enable_out, .synth_cal_out, .synth_enable_out,
  .rx_enable_out, .tx_enable_out);

// *** host_model.sv ***
/*
  Host model: issues command strobes on its own link clock and handles
  chip select. Assumes the ready flag is seen as a plain level.
*/
`timescale 1ns/1ps
module host_model (
  input wire logic ready_low_in,
  output logic link_clk_out,
  output logic strobe_valid_out,
  output radio_pkg::strobe_code_t strobe_code_out,
  output logic chip_select_low_out
);
  import radio_pkg::*;
  // Idle link: clock still, valid low, no chip select.
  initial
  begin
    link_clk_out = 1'b0;
    strobe_valid_out = 1'b0;
    strobe_code_out = 4'h0;
    chip_select_low_out = 1'b0;
  end
  // The link clock only runs when a task asks for edges, 6 ns a period.
  task automatic edges(input int n);
    repeat (n)
    begin
      #3 link_clk_out = 1'b1;
      #3 link_clk_out = 1'b0;
    end
  endtask
  task automatic cs_on();
    chip_select_low_out = 1'b1;
  endtask
  task automatic release_cs();
    chip_select_low_out = 1'b0;
  endtask
  // A transfer waits for the device to report ready, for at most 5000 polls of 8 ns.
  task automatic select();
    int i;
    cs_on();
    i = 0;
    while (ready_low_in !== 1'b0 && i < 5000)
    begin
      #8;
      i++;
    end
  endtask
  // The released code line shows the inverse so stale data never counts.
  task automatic send(input strobe_code_t c);
    select();
    strobe_code_out = c;
    strobe_valid_out = 1'b1;
    edges(1);
    strobe_valid_out = 1'b0;
    strobe_code_out = ~c;
    edges(3);
  endtask
endmodule

// *** radio_state_controller_tb.sv ***
/*
  Self-checking bench of the radio state controller.
  Assumes the host model drives the link side and the checker is bound.
*/
`timescale 1ns/1ps
`include "radio_cfg.svh"
module radio_state_controller_tb;
  import radio_pkg::*;
  logic clk_in, resetn_in, osc_stable, force_on, rssi_below, rcv_pkt;
  logic link_clk, valid, cs, ready_low, xosc, reg_en, rx_en, tx_en;
  select_t acal, aft_rx, aft_tx, cca;
  logic [4:0] evs;
  strobe_code_t code;
  state_number_t num;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  host_model host (.ready_low_in(ready_low), .link_clk_out(link_clk),
    .strobe_valid_out(valid), .strobe_code_out(code),
    .chip_select_low_out(cs));
  radio_state_controller #(.CAL_LEN(20)) uut (.clk_in(clk_in),
    .resetn_in(resetn_in), .link_clk_in(link_clk), .strobe_valid_in(valid),
    .strobe_code_in(code), .chip_select_low_in(cs),
    .osc_stable_in(osc_stable), .xosc_force_on_in(force_on),
    .auto_calibration_select_in(acal), .after_receive_state_in(aft_rx),
    .after_transmit_state_in(aft_tx), .clear_channel_mode_in(cca),
    .rssi_below_in(rssi_below), .receiving_packet_in(rcv_pkt),
    .packet_received_in(evs[0]), .packet_sent_in(evs[1]),
    .rx_timeout_in(evs[2]), .tx_underflow_in(evs[3]),
    .wor_wake_in(evs[4]), .ready_low_flag_out(ready_low),
    .radio_state_number_out(num), .xosc_enable_out(xosc),
    .regulator_enable_out(reg_en), .synth_cal_out(),
    .synth_enable_out(), .rx_enable_out(rx_en), .tx_enable_out(tx_en));
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // The ceiling is about two and a half times the expected run length.
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      fails = fails + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Strobes are spaced by eight core cycles so none gets merged.
  task automatic strobe(input strobe_code_t c);
    host.send(c);
    tick(8);
  endtask
  task automatic wait_st(input state_number_t n, input int lim);
    int i;
    i = 0;
    while (num !== n && i < lim)
    begin
      @(negedge clk_in);
      i++;
    end
    check("state", num, n);
  endtask
  task automatic pulse(input int i);
    @(posedge clk_in);
    evs[i] <= 1'b1;
    @(posedge clk_in);
    evs <= 5'h00;
  endtask
  task automatic t_power_on();
    check("state", num, 5'h03);
    host.cs_on();
    @(posedge clk_in);
    resetn_in <= 1'b1;
    // Link-side reset only clears once the link clock has run again.
    host.edges(2);
    tick(10);
    check("ready", ready_low, 1'b1);
    @(posedge clk_in);
    osc_stable <= 1'b1;
    wait_st(5'h01, 10);
    check("ready", ready_low, 1'b0);
    check("xosc", xosc, 1'b1);
  endtask
  task automatic t_rx_cca();
    strobe(`STROBE_RECEIVE);
    wait_st(5'h05, 4);
    wait_st(5'h06, 2310);
    check("rx_en", rx_en, 1'b1);
    @(posedge clk_in);
    rcv_pkt <= 1'b1;
    for (int m = 3; m > 0; m--)
    begin
      @(posedge clk_in);
      cca <= select_t'(m);
      strobe(`STROBE_TRANSMIT);
      check("state", num, 5'h06);
    end
    @(posedge clk_in);
    rssi_below <= 1'b1;
    tick(20);
    check("state", num, 5'h06);
    @(posedge clk_in);
    rssi_below <= 1'b0;
    cca <= `CCA_ALWAYS;
    strobe(`STROBE_TRANSMIT);
    wait_st(5'h09, 4);
    wait_st(5'h07, 260);
  endtask
  task automatic t_after();
    @(posedge clk_in);
    aft_tx <= `AFTER_RX;
    aft_rx <= `AFTER_TX;
    pulse(1);
    wait_st(5'h09, 10);
    wait_st(5'h06, 570);
    pulse(0);
    wait_st(5'h07, 260);
    strobe(`STROBE_RECEIVE);
    wait_st(5'h06, 570);
    @(posedge clk_in);
    aft_rx <= `AFTER_SYNTH;
    pulse(0);
    wait_st(5'h08, 260);
    strobe(`STROBE_TRANSMIT);
    wait_st(5'h07, 4);
    pulse(3);
    wait_st(5'h01, 8);
    @(posedge clk_in);
    aft_rx <= `AFTER_RX;
    pulse(4);
    wait_st(5'h06, 2310);
    pulse(0);
    tick(10);
    check("state", num, 5'h06);
    @(posedge clk_in);
    aft_rx <= `AFTER_IDLE;
    pulse(0);
    wait_st(5'h01, 8);
  endtask
  task automatic t_calib();
    @(posedge clk_in);
    acal <= `ACAL_FROM_IDLE;
    strobe(`STROBE_RECEIVE);
    wait_st(5'h04, 4);
    wait_st(5'h06, 2340);
    @(posedge clk_in);
    acal <= `ACAL_TO_IDLE;
    pulse(0);
    wait_st(5'h04, 8);
    wait_st(5'h01, 30);
    strobe(`STROBE_RECEIVE);
    wait_st(5'h06, 2310);
    strobe(`STROBE_IDLE);
    wait_st(5'h01, 4);
    strobe(`STROBE_CALIBRATE);
    wait_st(5'h04, 4);
    wait_st(5'h01, 30);
    @(posedge clk_in);
    acal <= `ACAL_FOURTH;
    host.send(`STROBE_RESET);
    wait_st(5'h03, 12);
    wait_st(5'h01, 12);
    for (int i = 0; i < 4; i++)
    begin
      strobe(`STROBE_RECEIVE);
      wait_st(5'h06, 2310);
      pulse(2);
      wait_st((i == 3) ? 5'h04 : 5'h01, 8);
      wait_st(5'h01, 30);
    end
  endtask
  task automatic t_sleep();
    strobe(`STROBE_RECEIVE);
    wait_st(5'h06, 2310);
    strobe(`STROBE_POWER_DOWN);
    check("state", num, 5'h06);
    strobe(`STROBE_IDLE);
    wait_st(5'h01, 4);
    for (int f = 0; f < 3; f++)
    begin
      @(posedge clk_in);
      force_on <= (f == 1);
      strobe((f == 2) ? `STROBE_OSC_OFF : `STROBE_POWER_DOWN);
      check("state", num, 5'h01);
      host.release_cs();
      wait_st((f == 2) ? 5'h02 : 5'h00, 10);
      check("xosc", xosc, (f == 1));
      check("reg_en", reg_en, (f == 2));
      host.select();
      wait_st(5'h01, 20);
      check("reg_en", reg_en, 1'b1);
    end
  endtask
  initial
  begin
    resetn_in = 1'b0;
    osc_stable = 1'b0;
    force_on = 1'b0;
    rssi_below = 1'b0;
    rcv_pkt = 1'b0;
    acal = `ACAL_NEVER;
    aft_rx = `AFTER_IDLE;
    aft_tx = `AFTER_IDLE;
    cca = `CCA_ALWAYS;
    evs = 5'h00;
    host.edges(4);
    tick(6);
    t_power_on();
    t_rx_cca();
    t_after();
    t_calib();
    t_sleep();
    stop_test();
  end
endmodule
